// ### rtl/pismr_params.svh
/*
  Constants for the identification and supply-monitor register bank:
  register indices, field positions, reset values and codes.
  Assumes it is included by bare name from the design, checker and bench files.
*/
`ifndef PISMR_PARAMS_SVH
`define PISMR_PARAMS_SVH

// ********************************************************************
// register indices (byte address is four times the index)
// ********************************************************************
`define PISMR_IDX_RESET_CHIP   16'h0000
`define PISMR_IDX_REVISION     16'h0001
`define PISMR_IDX_PARENT_CODE  16'h4000
`define PISMR_IDX_SUPPLY_CTRL  16'h4001
`define PISMR_IDX_THERMAL_CFG  16'h4002
`define PISMR_IDX_POWER_STATE  16'h4003
`define PISMR_IDX_IRQ_STATUS   16'h4010
`define PISMR_IDX_IRQ_MASK     16'h4011
`define PISMR_IDX_RESET_SCOPE  16'h4012

// ********************************************************************
// field positions
// ********************************************************************
`define PISMR_ACT_HI           15
`define PISMR_ACT_LO           14
`define PISMR_LOW_STS_BIT      11
`define PISMR_LOW_THR_HI       6
`define PISMR_LOW_THR_LO       4
`define PISMR_GOOD_THR_HI      2
`define PISMR_GOOD_THR_LO      0
`define PISMR_THERMAL_WARN_HYSTERESIS_BIT     3
`define PISMR_THERMAL_WARN_LEVEL_HI      1
`define PISMR_THERMAL_WARN_LEVEL_LO      0
`define PISMR_CHIP_ON_BIT      15
`define PISMR_IRQ_LOW_BIT      0
`define PISMR_IRQ_GOOD_BIT     1
`define PISMR_SCOPE_BIT        0

// ********************************************************************
// reset values and codes
// ********************************************************************
`define PISMR_RST_ACTION       2'b00
`define PISMR_RST_LOW_THR      3'b010
`define PISMR_RST_GOOD_THR     3'b101
`define PISMR_RST_THERMAL_WARN_HYSTERESIS     1'b1
`define PISMR_RST_THERMAL_WARN_LEVEL     2'b10
`define PISMR_RST_IRQ          2'b00
`define PISMR_RST_SCOPE        1'b0
`define PISMR_ACT_IRQ          2'b00
`define PISMR_ACT_WAKE         2'b01
`define PISMR_ACT_OFF          2'b11
`define PISMR_RESP_OKAY        2'b00
`define PISMR_RESP_SLVERR      2'b10

`endif

// ### rtl/pismr_pkg.sv
/*
  Types shared by the register bank: bus state machines, the
  configuration carrier and the module state record.
  Assumes the constants header is on the include path.
*/
package pismr_pkg;

  typedef enum logic [1:0] {
    PISMR_WR_IDLE = 2'b00,
    PISMR_WR_ADDR = 2'b01,
    PISMR_WR_RESP = 2'b11,
    PISMR_WR_DATA = 2'b10
  } pismr_wr_state_t;

  typedef enum logic {
    PISMR_RD_IDLE = 1'b0,
    PISMR_RD_RESP = 1'b1
  } pismr_rd_state_t;

  // settings handed to the analogue monitors
  typedef struct packed {
    logic [1:0] supplyLowAction;
    logic [2:0] supplyLowThreshold;
    logic [2:0] supplyGoodThreshold;
    logic       thermalWarnHysteresis;
    logic [1:0] thermalWarnLevel;
  } pismr_ctrl_t;

  typedef struct packed {
    pismr_wr_state_t wrState;
    pismr_rd_state_t rdState;
    logic [15:0]     wrIndex;
    logic [31:0]     wrData;
    logic [3:0]      wrStrb;
    logic [1:0]      bResp;
    logic [31:0]     rData;
    logic [1:0]      rResp;
    pismr_ctrl_t     ctrl;
    logic [1:0]      irqStatus;
    logic [1:0]      irqMask;
    logic            resetScope;
    logic            lowPrev;
    logic            goodPrev;
    logic            softReset;
    logic            wakeReq;
    logic            offReq;
  } pismr_state_t;

endpackage

// ### rtl/pismr_sync.sv
/*
  Three-stage input synchroniser with agreement filter, one per bit.
  Assumes inputs are asynchronous levels that change slowly.
*/
`timescale 1ns/1ps

module pismr_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } pismr_sync_state_t;

  pismr_sync_state_t st;
  pismr_sync_state_t next_st;
  logic [WIDTH-1:0]  agreed;

  // ******************************************************************
  // per-bit filter: a change counts once stages two and three agree
  // ******************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      assign agreed[gi] = (st.stage2[gi] == st.stage3[gi]) ? st.stage3[gi] : st.level[gi];
    end
  endgenerate

  always_comb begin
    next_st        = st;
    next_st.stage1 = asyncIn;
    next_st.stage2 = st.stage1;
    next_st.stage3 = st.stage2;
    next_st.level  = agreed;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign syncOut = st.level;

endmodule

// ### rtl/pismr_regs.sv
/*
  Identification, supply-monitor and thermal-warning register bank
  behind an AXI4-Lite slave, with a sticky interrupt status.
  Assumes one clock, synchronous reset, comparator outputs arriving
  asynchronously, and a power-state level from logic on this clock.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
// Summary of operation
// R1: any write to index zero pulses software reset
// R2: scope setting decides whether contents return default
// R3: index zero reads chip code, never resets
// R4: revision upper byte is main die revision
// R5: revision lower byte is secondary die revision
// R6: parent code register returns fixed identifier
// R7: action field picks interrupt, wake or off
// R8: status bit eleven mirrors supply-low comparator
// R9: bits six to four select falling threshold
// R10: bits two to zero select rising threshold
// R11: good detector adds hysteresis above code
// R12: supply-low status bit ignores software writes
// R13: chip-on zero commands off, one ignored
`timescale 1ns/1ps

`include "pismr_params.svh"

module pismr_regs
  import pismr_pkg::*;
#(
  parameter int          ADDR_W        = 18,
  // arbitrary values, replace per product
  parameter logic [15:0] DEVICE_IDENT  = 16'h1A2B,
  parameter logic [15:0] MAIN_DIE_IDENT = 16'h3C4D,
  parameter logic [7:0]  MAIN_DIE_REV  = 8'h00,
  parameter logic [7:0]  SEC_DIE_REV   = 8'h00
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // comparators, asynchronous levels
  input  wire logic              supplyLowFlag,
  input  wire logic              supplyGoodFlag,
  // power state machine
  input  wire logic              chipOnState,
  output logic                   softResetPulse,
  output logic                   softResetScope,
  output logic                   wakeRequest,
  output logic                   offRequest,
  // monitor settings
  output pismr_ctrl_t            monitorCtrl,
  // interrupt
  output logic                   irq
);

  pismr_state_t st;
  pismr_state_t next_st;
  logic [1:0]   syncFlags;
  logic         lowLevel;
  logic         goodLevel;

  // ******************************************************************
  // comparator inputs
  // ******************************************************************
  pismr_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({supplyGoodFlag, supplyLowFlag}),
    .syncOut (syncFlags)
  );

  assign lowLevel  = syncFlags[0];
  assign goodLevel = syncFlags[1];

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res[7:0]  = strb[0] ? data[7:0]  : old[7:0];
    res[15:8] = strb[1] ? data[15:8] : old[15:8];
    return res;
  endfunction

  function automatic logic mapped(input logic [15:0] idx);
    logic hit;
    hit = 1'b0;
    if (idx <= `PISMR_IDX_REVISION) begin
      hit = 1'b1;
    end else if (idx >= `PISMR_IDX_PARENT_CODE && idx <= `PISMR_IDX_POWER_STATE) begin
      hit = 1'b1;
    end else if (idx >= `PISMR_IDX_IRQ_STATUS && idx <= `PISMR_IDX_RESET_SCOPE) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // ******************************************************************
  // next state
  // ******************************************************************
  logic        doWrite;
  logic [15:0] wIdx;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic [15:0] cur16;
  logic [15:0] new16;
  logic [15:0] rIdx;
  logic [15:0] rVal;
  logic [1:0]  lowSet;
  logic [1:0]  clearBits;

  always_comb begin
    next_st           = st;
    next_st.softReset = 1'b0;
    next_st.wakeReq   = 1'b0;
    next_st.offReq    = 1'b0;
    next_st.lowPrev   = lowLevel;
    next_st.goodPrev  = goodLevel;
    doWrite           = 1'b0;
    wIdx              = st.wrIndex;
    wData             = st.wrData;
    wStrb             = st.wrStrb;
    cur16             = 16'h0000;
    new16             = 16'h0000;
    rIdx              = s_axi_araddr[17:2];
    rVal              = 16'h0000;
    lowSet            = 2'b00;
    clearBits         = 2'b00;

    // write channel: address and data in either order
    case (st.wrState)
      PISMR_WR_IDLE: begin
        if (s_axi_awvalid && s_axi_wvalid) begin
          doWrite = 1'b1;
          wIdx    = s_axi_awaddr[17:2];
          wData   = s_axi_wdata;
          wStrb   = s_axi_wstrb;
        end else if (s_axi_awvalid) begin
          next_st.wrIndex = s_axi_awaddr[17:2];
          next_st.wrState = PISMR_WR_ADDR;
        end else if (s_axi_wvalid) begin
          next_st.wrData  = s_axi_wdata;
          next_st.wrStrb  = s_axi_wstrb;
          next_st.wrState = PISMR_WR_DATA;
        end
      end
      PISMR_WR_ADDR: begin
        if (s_axi_wvalid) begin
          doWrite = 1'b1;
          wData   = s_axi_wdata;
          wStrb   = s_axi_wstrb;
        end
      end
      PISMR_WR_DATA: begin
        if (s_axi_awvalid) begin
          doWrite = 1'b1;
          wIdx    = s_axi_awaddr[17:2];
        end
      end
      PISMR_WR_RESP: begin
        if (s_axi_bready) begin
          next_st.wrState = PISMR_WR_IDLE;
        end
      end
      default: begin
        next_st.wrState = PISMR_WR_IDLE;
      end
    endcase

    if (doWrite) begin
      next_st.wrState = PISMR_WR_RESP;
      next_st.bResp   = mapped(wIdx) ? `PISMR_RESP_OKAY : `PISMR_RESP_SLVERR;
      if (wIdx == `PISMR_IDX_RESET_CHIP) begin
        // any write, any data or strobes
        next_st.softReset = 1'b1; // [R1]
        if (st.resetScope) begin
          next_st.ctrl.supplyLowAction       = `PISMR_RST_ACTION; // [R2]
          next_st.ctrl.supplyLowThreshold    = `PISMR_RST_LOW_THR;
          next_st.ctrl.supplyGoodThreshold   = `PISMR_RST_GOOD_THR;
          next_st.ctrl.thermalWarnHysteresis = `PISMR_RST_THERMAL_WARN_HYSTERESIS;
          next_st.ctrl.thermalWarnLevel      = `PISMR_RST_THERMAL_WARN_LEVEL;
          next_st.irqStatus                  = `PISMR_RST_IRQ;
          next_st.irqMask                    = `PISMR_RST_IRQ;
        end
      end else if (wIdx == `PISMR_IDX_SUPPLY_CTRL) begin
        cur16 = {st.ctrl.supplyLowAction, 7'h00, st.ctrl.supplyLowThreshold,
                 1'b0, st.ctrl.supplyGoodThreshold};
        new16 = merge16(cur16, wData, wStrb);
        next_st.ctrl.supplyLowAction     = new16[`PISMR_ACT_HI:`PISMR_ACT_LO]; // [R7]
        next_st.ctrl.supplyLowThreshold  = new16[`PISMR_LOW_THR_HI:`PISMR_LOW_THR_LO]; // [R9]
        next_st.ctrl.supplyGoodThreshold = new16[`PISMR_GOOD_THR_HI:`PISMR_GOOD_THR_LO]; // [R10]
        // status bit has no storage, so a write cannot touch it [R12]
      end else if (wIdx == `PISMR_IDX_THERMAL_CFG) begin
        cur16 = {12'h000, st.ctrl.thermalWarnHysteresis, 1'b0, st.ctrl.thermalWarnLevel};
        new16 = merge16(cur16, wData, wStrb);
        next_st.ctrl.thermalWarnHysteresis = new16[`PISMR_THERMAL_WARN_HYSTERESIS_BIT];
        next_st.ctrl.thermalWarnLevel      = new16[`PISMR_THERMAL_WARN_LEVEL_HI:`PISMR_THERMAL_WARN_LEVEL_LO];
      end else if (wIdx == `PISMR_IDX_POWER_STATE) begin
        if (wStrb[1] && !wData[`PISMR_CHIP_ON_BIT]) begin
          next_st.offReq = 1'b1; // [R13]
        end
      end else if (wIdx == `PISMR_IDX_IRQ_STATUS) begin
        if (wStrb[0]) begin
          clearBits = wData[1:0];
        end
      end else if (wIdx == `PISMR_IDX_IRQ_MASK) begin
        if (wStrb[0]) begin
          next_st.irqMask = wData[1:0];
        end
      end else if (wIdx == `PISMR_IDX_RESET_SCOPE) begin
        if (wStrb[0]) begin
          next_st.resetScope = wData[`PISMR_SCOPE_BIT];
        end
      end
    end

    // supply-low assertion takes the selected action
    if (lowLevel && !st.lowPrev) begin
      case (st.ctrl.supplyLowAction)
        `PISMR_ACT_IRQ: begin
          lowSet[`PISMR_IRQ_LOW_BIT] = 1'b1; // [R7]
        end
        `PISMR_ACT_WAKE: begin
          next_st.wakeReq = 1'b1; // [R7]
        end
        `PISMR_ACT_OFF: begin
          next_st.offReq = 1'b1; // [R7]
        end
        default: begin
          lowSet = 2'b00;
        end
      endcase
    end
    // the comparator applies its margin above the programmed code [R11]
    if (goodLevel && !st.goodPrev) begin
      lowSet[`PISMR_IRQ_GOOD_BIT] = 1'b1;
    end
    // set wins over a clear in the same cycle
    next_st.irqStatus = (next_st.irqStatus & ~clearBits) | lowSet;

    // read channel
    case (st.rdState)
      PISMR_RD_IDLE: begin
        if (s_axi_arvalid) begin
          if (rIdx == `PISMR_IDX_RESET_CHIP) begin
            rVal = DEVICE_IDENT; // [R3]
          end else if (rIdx == `PISMR_IDX_REVISION) begin
            rVal = {MAIN_DIE_REV, SEC_DIE_REV}; // [R4] [R5]
          end else if (rIdx == `PISMR_IDX_PARENT_CODE) begin
            rVal = MAIN_DIE_IDENT; // [R6]
          end else if (rIdx == `PISMR_IDX_SUPPLY_CTRL) begin
            rVal = {st.ctrl.supplyLowAction, 2'b00, lowLevel, 4'h0,
                    st.ctrl.supplyLowThreshold, 1'b0,
                    st.ctrl.supplyGoodThreshold}; // [R8]
          end else if (rIdx == `PISMR_IDX_THERMAL_CFG) begin
            rVal = {12'h000, st.ctrl.thermalWarnHysteresis, 1'b0,
                    st.ctrl.thermalWarnLevel};
          end else if (rIdx == `PISMR_IDX_POWER_STATE) begin
            rVal = {chipOnState, 15'h0000};
          end else if (rIdx == `PISMR_IDX_IRQ_STATUS) begin
            rVal = {14'h0000, st.irqStatus};
          end else if (rIdx == `PISMR_IDX_IRQ_MASK) begin
            rVal = {14'h0000, st.irqMask};
          end else if (rIdx == `PISMR_IDX_RESET_SCOPE) begin
            rVal = {15'h0000, st.resetScope};
          end
          next_st.rData   = {16'h0000, rVal};
          next_st.rResp   = mapped(rIdx) ? `PISMR_RESP_OKAY : `PISMR_RESP_SLVERR;
          next_st.rdState = PISMR_RD_RESP;
        end
      end
      PISMR_RD_RESP: begin
        if (s_axi_rready) begin
          next_st.rdState = PISMR_RD_IDLE;
        end
      end
      default: begin
        next_st.rdState = PISMR_RD_IDLE;
      end
    endcase
  end

  // ******************************************************************
  // state register
  // ******************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st                            <= '0;
      st.wrState                    <= PISMR_WR_IDLE;
      st.rdState                    <= PISMR_RD_IDLE;
      st.ctrl.supplyLowAction       <= `PISMR_RST_ACTION;
      st.ctrl.supplyLowThreshold    <= `PISMR_RST_LOW_THR;
      st.ctrl.supplyGoodThreshold   <= `PISMR_RST_GOOD_THR;
      st.ctrl.thermalWarnHysteresis <= `PISMR_RST_THERMAL_WARN_HYSTERESIS;
      st.ctrl.thermalWarnLevel      <= `PISMR_RST_THERMAL_WARN_LEVEL;
      st.irqStatus                  <= `PISMR_RST_IRQ;
      st.irqMask                    <= `PISMR_RST_IRQ;
      st.resetScope                 <= `PISMR_RST_SCOPE;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  assign s_axi_awready  = (st.wrState == PISMR_WR_IDLE) || (st.wrState == PISMR_WR_DATA);
  assign s_axi_wready   = (st.wrState == PISMR_WR_IDLE) || (st.wrState == PISMR_WR_ADDR);
  assign s_axi_bvalid   = (st.wrState == PISMR_WR_RESP);
  assign s_axi_bresp    = st.bResp;
  assign s_axi_arready  = (st.rdState == PISMR_RD_IDLE);
  assign s_axi_rvalid   = (st.rdState == PISMR_RD_RESP);
  assign s_axi_rdata    = st.rData;
  assign s_axi_rresp    = st.rResp;
  assign softResetPulse = st.softReset;
  assign softResetScope = st.resetScope;
  assign wakeRequest    = st.wakeReq;
  assign offRequest     = st.offReq;
  assign monitorCtrl    = st.ctrl;
  assign irq            = |(st.irqStatus & st.irqMask);

endmodule

// ### sim/pismr_regs_properties.sv
/*
  Port checker for the register bank.
  Assumes a bind into pismr_regs; sees its ports only.
*/
`timescale 1ns/1ps

`include "pismr_params.svh"

module pismr_regs_checker
  import pismr_pkg::*;
#(
  parameter int          ADDR_W         = 18,
  parameter logic [15:0] DEVICE_IDENT   = 16'h1A2B,
  parameter logic [15:0] MAIN_DIE_IDENT = 16'h3C4D,
  parameter logic [7:0]  MAIN_DIE_REV   = 8'h00,
  parameter logic [7:0]  SEC_DIE_REV    = 8'h00
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  // power and monitor side
  input wire logic              softResetPulse,
  input wire logic              softResetScope,
  input wire logic              wakeRequest,
  input wire logic              offRequest,
  input wire pismr_ctrl_t       monitorCtrl,
  input wire logic              irq
);
  localparam logic [10:0] CTRL_DEF = {`PISMR_RST_ACTION, `PISMR_RST_LOW_THR,
    `PISMR_RST_GOOD_THR, `PISMR_RST_THERMAL_WARN_HYSTERESIS, `PISMR_RST_THERMAL_WARN_LEVEL};
  wire logic [1:0] lowAction = monitorCtrl.supplyLowAction;
  wire logic       readTaken = s_axi_arvalid && s_axi_arready;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ********************************************************
  // properties
  // ********************************************************
  soft_pulse_a: assert property (
    softResetPulse |-> $rose(s_axi_bvalid) ##1 !softResetPulse)
    else $error("soft reset pulse not tied to one write");
  reset_scope_a: assert property (
    softResetPulse |-> (softResetScope ? monitorCtrl == CTRL_DEF : $stable(monitorCtrl)))
    else $error("soft reset scope not honoured");
  chip_code_a: assert property (
    readTaken && s_axi_araddr[ADDR_W-1:2] == `PISMR_IDX_RESET_CHIP
    |=> s_axi_rvalid && s_axi_rdata == {16'h0000, DEVICE_IDENT})
    else $error("chip code read wrong");
  die_rev_a: assert property (
    readTaken && s_axi_araddr[ADDR_W-1:2] == `PISMR_IDX_REVISION
    |=> s_axi_rdata == {16'h0000, MAIN_DIE_REV, SEC_DIE_REV})
    else $error("revision read wrong");
  parent_code_a: assert property (
    readTaken && s_axi_araddr[ADDR_W-1:2] == `PISMR_IDX_PARENT_CODE
    |=> s_axi_rdata == {16'h0000, MAIN_DIE_IDENT})
    else $error("parent code read wrong");
  wake_action_a: assert property (
    wakeRequest |-> $past(lowAction) == `PISMR_ACT_WAKE)
    else $error("wake request without wake action");
  off_action_a: assert property (
    offRequest |-> $past(lowAction) == `PISMR_ACT_OFF || $rose(s_axi_bvalid))
    else $error("off request without cause");
  reset_defaults_a: assert property (
    $fell(sys_rst) |-> monitorCtrl == CTRL_DEF && !irq && s_axi_arready && !s_axi_bvalid)
    else $error("defaults wrong after reset");
  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule

bind pismr_regs pismr_regs_checker #(
  .ADDR_W(ADDR_W), .DEVICE_IDENT(DEVICE_IDENT), .MAIN_DIE_IDENT(MAIN_DIE_IDENT),
  .MAIN_DIE_REV(MAIN_DIE_REV), .SEC_DIE_REV(SEC_DIE_REV)
) checker_i (.*);

// ### sim/tb_top.sv
/*
  Self-checking bench for the register bank.
  Assumes package, design and checker are compiled first.
*/
`timescale 1ns/1ps

`include "pismr_params.svh"

module tb_top
  import pismr_pkg::*;
;
  // arbitrary values
  localparam logic [15:0] DEV_ID   = 16'h5E61;
  localparam logic [15:0] MAIN_ID  = 16'h7A13;
  localparam logic [7:0]  MAIN_REV = 8'h21;
  localparam logic [7:0]  SEC_REV  = 8'h04;
  logic        clk, sys_rst, supplyLowFlag, supplyGoodFlag, chipOnState, irq;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        softResetPulse, softResetScope, wakeRequest, offRequest;
  pismr_ctrl_t monitorCtrl, c;
  int          num_errors = 0, comparisons = 0, rstCnt = 0, wakeCnt = 0, offCnt = 0, n, m;

  pismr_regs #(.DEVICE_IDENT(DEV_ID), .MAIN_DIE_IDENT(MAIN_ID), .MAIN_DIE_REV(MAIN_REV),
    .SEC_DIE_REV(SEC_REV)) DUT (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (softResetPulse === 1'b1) rstCnt++;
    if (wakeRequest === 1'b1) wakeCnt++;
    if (offRequest === 1'b1) offCnt++;
  end

  // ********************************************************
  // helpers
  // ********************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] dat, input logic [3:0] st);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= dat;
    s_axi_wstrb   <= st;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'($urandom_range(1));
    while (!(a && w)) begin
      @(negedge clk);
      if (s_axi_awvalid && s_axi_awready) a = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w = 1'b1;
      @(posedge clk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(negedge clk);
    rsp = s_axi_bresp;
    if (!s_axi_bready) @(posedge clk) s_axi_bready <= 1'b1;
    @(posedge clk);
    s_axi_bready <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'($urandom_range(1));
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    if (!s_axi_rready) @(posedge clk) s_axi_rready <= 1'b1;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    @(negedge clk);
    check(rd, exp);
    check(rsp, er);
  endtask

  function automatic logic [31:0] ctrlRead(input logic [15:0] v, input logic low);
    return {16'h0000, v[15:14], 2'b00, low, 4'h0, v[6:4], 1'b0, v[2:0]};
  endfunction

  task automatic complete_run();
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    {sys_rst, supplyLowFlag, supplyGoodFlag, chipOnState} = 4'b1000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    void'($urandom(63406));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check(monitorCtrl, 11'h0AE);
    rchk(`PISMR_IDX_RESET_CHIP, {16'h0000, DEV_ID}, `PISMR_RESP_OKAY);
    check(rstCnt, 0);
    rchk(`PISMR_IDX_SUPPLY_CTRL, 32'h0000_0025, `PISMR_RESP_OKAY);
    rchk(`PISMR_IDX_THERMAL_CFG, 32'h0000_000A, `PISMR_RESP_OKAY);
    rchk(16'h0100, 32'h0000_0000, `PISMR_RESP_SLVERR);
    for (int i = 0; i < 12; i++) begin
      d = $urandom();
      wr(`PISMR_IDX_SUPPLY_CTRL, d, 4'hF);
      rchk(`PISMR_IDX_SUPPLY_CTRL, ctrlRead(d[15:0], 1'b0), `PISMR_RESP_OKAY);
      wr(`PISMR_IDX_THERMAL_CFG, d, 4'hF);
      rchk(`PISMR_IDX_THERMAL_CFG, {28'h0, d[3], 1'b0, d[1:0]}, `PISMR_RESP_OKAY);
      check(monitorCtrl, {d[15:14], d[6:4], d[2:0], d[3], d[1:0]});
      wr(`PISMR_IDX_REVISION, d, 4'hF);
      wr(`PISMR_IDX_PARENT_CODE, ~d, 4'hF);
      rchk(`PISMR_IDX_REVISION, {16'h0000, MAIN_REV, SEC_REV}, `PISMR_RESP_OKAY);
      rchk(`PISMR_IDX_PARENT_CODE, {16'h0000, MAIN_ID}, `PISMR_RESP_OKAY);
    end
    wr(16'h0200, $urandom(), 4'hF);
    check(rsp, `PISMR_RESP_SLVERR);
    c = monitorCtrl;
    wr(`PISMR_IDX_RESET_CHIP, $urandom(), 4'h0);
    check(rstCnt, 1);
    check(monitorCtrl, c);
    wr(`PISMR_IDX_RESET_SCOPE, 32'h1, 4'h1);
    wr(`PISMR_IDX_RESET_CHIP, $urandom(), 4'hF);
    check(rstCnt, 2);
    check(monitorCtrl, 11'h0AE);
    check(softResetScope, 1'b1);
    wr(`PISMR_IDX_IRQ_MASK, 32'h1, 4'h1);
    for (int a = 0; a < 4; a++) begin
      wr(`PISMR_IDX_SUPPLY_CTRL, {16'h0000, a[1:0], 14'h0025}, 4'h3);
      n = wakeCnt;
      m = offCnt;
      @(posedge clk);
      supplyLowFlag <= 1'b1;
      repeat (8) @(negedge clk);
      check(irq, a == 0);
      check(wakeCnt, n + (a == 1));
      check(offCnt, m + (a == 3));
      rchk(`PISMR_IDX_SUPPLY_CTRL, ctrlRead({a[1:0], 14'h0025}, 1'b1), 2'b00);
      rchk(`PISMR_IDX_IRQ_STATUS, 32'(a == 0), `PISMR_RESP_OKAY);
      @(posedge clk);
      supplyLowFlag <= 1'b0;
      repeat (8) @(negedge clk);
      wr(`PISMR_IDX_IRQ_STATUS, 32'h3, 4'h1);
      check(irq, 1'b0);
    end
    @(posedge clk);
    supplyGoodFlag <= 1'b1;
    repeat (8) @(negedge clk);
    check(irq, 1'b0);
    rchk(`PISMR_IDX_IRQ_STATUS, 32'h2, `PISMR_RESP_OKAY);
    wr(`PISMR_IDX_IRQ_MASK, 32'h2, 4'h1);
    check(irq, 1'b1);
    wr(`PISMR_IDX_IRQ_STATUS, 32'h2, 4'h1);
    check(irq, 1'b0);
    @(posedge clk);
    chipOnState <= 1'($urandom_range(1));
    m = offCnt;
    wr(`PISMR_IDX_POWER_STATE, 32'h8000, 4'h3);
    check(offCnt, m);
    wr(`PISMR_IDX_POWER_STATE, 32'h0000, 4'h3);
    check(offCnt, m + 1);
    rchk(`PISMR_IDX_POWER_STATE, {16'h0000, chipOnState, 15'h0000}, `PISMR_RESP_OKAY);
    rchk(`PISMR_IDX_RESET_CHIP, {16'h0000, DEV_ID}, `PISMR_RESP_OKAY);
    check(rstCnt, 2);
    complete_run();
  end
endmodule
